// file: rtl/afc_map.vh
// register map, field positions, reset values and bus codes of the
// sampling and clamp control block; definitions only
`ifndef AFC_MAP_VH
`define AFC_MAP_VH

// ********************************************************
// register offsets (byte addresses)
// ********************************************************
`define AFC_SWRESET_OFS 8'h00
`define AFC_SETUP_OFS 8'h04
`define AFC_STATUS_OFS 8'h08
`define AFC_OFFSET_BASE 8'h10
`define AFC_GAIN_BASE 8'h20

// ********************************************************
// setup register fields
// ********************************************************
`define AFC_MODE_LSB 0
`define AFC_SEL_LSB 2
`define AFC_AUTO_BIT 4
`define AFC_ICLAMP_BIT 5
`define AFC_CPOS_LSB 6
`define AFC_DAC_LSB 8
`define AFC_EXTREF_BIT 12
`define AFC_NIBBLE_BIT 13

// ********************************************************
// modes and reset values
// ********************************************************
`define AFC_MODE_PIXEL 2'h0
`define AFC_MODE_MONO 2'h1
`define AFC_MODE_LINE 2'h2
`define AFC_SETUP_RST 14'h0000
`define AFC_OFFSET_RST 9'h080
`define AFC_OFFSET_CODE_RST 8'h80
`define AFC_SEL_RST 2'h0
`define AFC_GAIN_RST 9'h000

// ********************************************************
// ahb-lite codes
// ********************************************************
`define AFC_HTRANS_NONSEQ 2'h2

`endif

// file: rtl/afc_coef_mem.v
// gain and offset coefficient store, eight entries of nine bits
// assumes a synchronous active high reset that restores the defaults
`timescale 1ns/1ns
`include "afc_map.vh"

module afc_coef_mem #(
    parameter WIDTH = 9,
    parameter DEPTH = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire wr_en_i,
    input wire [2:0] wr_addr_i,
    input wire [WIDTH-1:0] wr_data_i,
    input wire rd_en_i,
    input wire [2:0] rd_addr_i,
    output reg [WIDTH-1:0] rd_data_o,
    output wire [DEPTH*WIDTH-1:0] contents_o
);

    // ********************************************************
    // storage: entries 0..3 offsets, 4..7 gains
    // ********************************************************
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ent
            reg [WIDTH-1:0] ent_q;
            // entry write, defaults on reset
            always @(posedge clk_i) begin
                if (rst_i) begin
                    ent_q <= (gi < 4) ? `AFC_OFFSET_RST : `AFC_GAIN_RST;
                end else if (wr_en_i && (wr_addr_i == gi)) begin
                    ent_q <= wr_data_i;
                end
            end
            assign contents_o[gi*WIDTH +: WIDTH] = ent_q;
        end
    endgenerate

    // registered read port
    always @(posedge clk_i) begin
        if (rst_i) begin
            rd_data_o <= {WIDTH{1'b0}};
        end else if (rd_en_i) begin
            rd_data_o <= contents_o[rd_addr_i*WIDTH +: WIDTH];
        end
    end

endmodule // afc_coef_mem

// file: rtl/afc_ctrl.v
// sampling mode, channel routing and reset level clamp control
// assumes one clock, synchronous inputs and a single ahb-lite master
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "afc_map.vh"

module afc_ctrl (
    input wire REF_CLK_I,
    input wire RST_I,
    input wire ANALOGUE_SUPPLY_OK_I,
    input wire DIGITAL_CORE_SUPPLY_OK_I,
    input wire VIDEO_SAMPLE_STROBE_I,
    input wire CLAMP_OR_CYCLE_PIN_I,
    input wire HSEL_I,
    input wire [7:0] HADDR_I,
    input wire [1:0] HTRANS_I,
    input wire HWRITE_I,
    input wire [2:0] HSIZE_I,
    input wire [31:0] HWDATA_I,
    input wire HREADY_I,
    output reg HREADYOUT_O,
    output reg HRESP_O,
    output reg [31:0] HRDATA_O,
    output reg POWER_ON_RESET_N_O,
    output reg [2:0] SAMPLE_ENABLE_O,
    output reg [1:0] RED_CHANNEL_SOURCE_O,
    output reg [2:0] CHANNEL_POWER_O,
    output reg [23:0] CHANNEL_OFFSET_O,
    output reg [26:0] CHANNEL_GAIN_O,
    output reg INTERNAL_CLAMP_PULSE_O,
    output reg [1:0] CLAMP_POSITION_SELECT_O,
    output reg [3:0] CLAMP_DAC_CODE_O,
    output reg CLAMP_DAC_ENABLE_O,
    output reg OUTPUT_NIBBLE_MODE_O
);

    // ********************************************************
    // power-on reset and internal reset
    // ********************************************************
    reg por_n_q;
    reg swrst_q;
    wire ctl_rst;

    // power-on reset follows both supply monitors
    always @(posedge REF_CLK_I) begin
        if (RST_I) begin
            por_n_q <= 1'b0;
        end else begin
            por_n_q <= ANALOGUE_SUPPLY_OK_I & DIGITAL_CORE_SUPPLY_OK_I;
        end
    end

    // control registers return to defaults under any reset source
    assign ctl_rst = RST_I | ~por_n_q | swrst_q;

    // ********************************************************
    // ahb-lite slave
    // ********************************************************
    reg wr_pend_q;
    reg rd_pend_q;
    reg rd_pend2_q;
    reg [7:0] addr_q;
    reg [13:0] setup_q;
    reg [1:0] sel_q;
    reg clamp_dec_q; // held clamp decision, also shown in status
    wire take;
    wire wr_go;
    wire addr_is_coef;
    wire [2:0] coef_idx;
    wire [8:0] coef_rd;
    wire [71:0] coef_all;

    assign take = HSEL_I & HREADY_I & (HTRANS_I == `AFC_HTRANS_NONSEQ);
    // writes are dropped while power-on reset holds
    assign wr_go = wr_pend_q & por_n_q;
    assign addr_is_coef = ((addr_q[7:4] == 4'h1) || (addr_q[7:4] == 4'h2)) &&
                          (addr_q[3:2] != 2'h3) && (addr_q[1:0] == 2'h0);
    assign coef_idx = {addr_q[5], addr_q[3:2]};

    // address phase capture and read pipeline
    always @(posedge REF_CLK_I) begin
        if (RST_I) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            rd_pend2_q <= 1'b0;
            addr_q <= 8'h00;
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end else begin
            wr_pend_q <= take & HWRITE_I;
            rd_pend_q <= take & ~HWRITE_I;
            rd_pend2_q <= rd_pend_q;
            if (take) begin
                addr_q <= HADDR_I;
            end
            if (take & ~HWRITE_I) begin
                HREADYOUT_O <= 1'b0;
            end else if (rd_pend2_q) begin
                HREADYOUT_O <= 1'b1;
            end
            HRESP_O <= 1'b0;
        end
    end

    // one-cycle software reset on any write to its address
    always @(posedge REF_CLK_I) begin
        if (RST_I) begin
            swrst_q <= 1'b0;
        end else begin
            swrst_q <= wr_go & (addr_q == `AFC_SWRESET_OFS);
        end
    end

    // coefficient store
    afc_coef_mem #(
        .WIDTH(9),
        .DEPTH(8)
    ) u_coef (
        .clk_i(REF_CLK_I),
        .rst_i(ctl_rst),
        .wr_en_i(wr_go & addr_is_coef),
        .wr_addr_i(coef_idx),
        .wr_data_i(HWDATA_I[8:0]),
        .rd_en_i(rd_pend_q),
        .rd_addr_i(coef_idx),
        .rd_data_o(coef_rd),
        .contents_o(coef_all)
    );

    // read data mux, registered one cycle after the store read
    always @(posedge REF_CLK_I) begin
        if (RST_I) begin
            HRDATA_O <= 32'h0000_0000;
        end else if (rd_pend2_q) begin
            if (addr_is_coef) begin
                HRDATA_O <= {23'h00_0000, coef_rd};
            end else if (addr_q == `AFC_SETUP_OFS) begin
                HRDATA_O <= {18'h0_0000, setup_q[13:4], sel_q, setup_q[1:0]};
            end else if (addr_q == `AFC_STATUS_OFS) begin
                HRDATA_O <= {25'h000_0000, por_n_q, clamp_dec_q, CHANNEL_POWER_O, sel_q};
            end else begin
                HRDATA_O <= 32'h0000_0000;
            end
        end
    end

    // ********************************************************
    // setup register and input selection
    // ********************************************************
    reg pin_q;
    wire [1:0] mode;
    wire auto_on;
    wire cycle_pulse;

    assign mode = setup_q[`AFC_MODE_LSB +: 2];
    assign auto_on = setup_q[`AFC_AUTO_BIT];
    assign cycle_pulse = auto_on & (mode == `AFC_MODE_LINE) & CLAMP_OR_CYCLE_PIN_I & ~pin_q;

    // setup write
    always @(posedge REF_CLK_I) begin
        if (ctl_rst) begin
            setup_q <= `AFC_SETUP_RST;
        end else if (wr_go && (addr_q == `AFC_SETUP_OFS)) begin
            setup_q <= HWDATA_I[13:0];
        end
    end

    // current input: written by software or advanced by cycle pulses
    always @(posedge REF_CLK_I) begin
        if (ctl_rst) begin
            sel_q <= `AFC_SEL_RST;
            pin_q <= 1'b0;
        end else begin
            pin_q <= CLAMP_OR_CYCLE_PIN_I;
            if (wr_go && (addr_q == `AFC_SETUP_OFS)) begin
                sel_q <= (HWDATA_I[`AFC_SEL_LSB +: 2] == 2'h3) ? 2'h0 : HWDATA_I[`AFC_SEL_LSB +: 2];
            end else if (cycle_pulse) begin
                sel_q <= (sel_q == 2'h2) ? 2'h0 : sel_q + 2'h1;
            end
        end
    end

    // ********************************************************
    // channel routing, power and coefficients
    // ********************************************************
    // sample enables, red source and channel power per mode
    always @(posedge REF_CLK_I) begin
        if (ctl_rst) begin
            SAMPLE_ENABLE_O <= 3'h7;
            RED_CHANNEL_SOURCE_O <= 2'h0;
            CHANNEL_POWER_O <= 3'h7;
        end else begin
            case (mode)
                `AFC_MODE_PIXEL: begin
                    SAMPLE_ENABLE_O <= 3'h7;
                    RED_CHANNEL_SOURCE_O <= 2'h0;
                    CHANNEL_POWER_O <= 3'h7;
                end
                `AFC_MODE_MONO: begin
                    SAMPLE_ENABLE_O <= 3'h1 << sel_q;
                    RED_CHANNEL_SOURCE_O <= 2'h0;
                    CHANNEL_POWER_O <= 3'h7;
                end
                `AFC_MODE_LINE: begin
                    SAMPLE_ENABLE_O <= 3'h1 << sel_q;
                    RED_CHANNEL_SOURCE_O <= sel_q;
                    CHANNEL_POWER_O <= 3'h1;
                end
                default: begin
                    SAMPLE_ENABLE_O <= 3'h7;
                    RED_CHANNEL_SOURCE_O <= 2'h0;
                    CHANNEL_POWER_O <= 3'h7;
                end
            endcase
        end
    end

    // per channel codes; red takes the selected set in line mode
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : g_ch
            localparam [31:0] ch_idx = ch;
            wire [1:0] src;
            assign src = ((ch == 0) && (mode == `AFC_MODE_LINE)) ? sel_q : ch_idx[1:0];
            always @(posedge REF_CLK_I) begin
                if (ctl_rst) begin
                    CHANNEL_OFFSET_O[ch*8 +: 8] <= `AFC_OFFSET_CODE_RST;
                    CHANNEL_GAIN_O[ch*9 +: 9] <= `AFC_GAIN_RST;
                end else begin
                    CHANNEL_OFFSET_O[ch*8 +: 8] <= coef_all[src*9 +: 8];
                    CHANNEL_GAIN_O[ch*9 +: 9] <= coef_all[(src+4)*9 +: 9];
                end
            end
        end
    endgenerate

    // ********************************************************
    // reset level clamp
    // ********************************************************
    reg strobe_q;
    reg armed_q;
    reg [1:0] cnt_q;

    // decision taken on the first edge inside each strobe
    always @(posedge REF_CLK_I) begin
        if (ctl_rst) begin
            strobe_q <= 1'b0;
            clamp_dec_q <= 1'b0;
        end else begin
            strobe_q <= VIDEO_SAMPLE_STROBE_I;
            if (VIDEO_SAMPLE_STROBE_I & ~strobe_q) begin
                if (auto_on) begin
                    clamp_dec_q <= setup_q[`AFC_ICLAMP_BIT];
                end else begin
                    clamp_dec_q <= CLAMP_OR_CYCLE_PIN_I;
                end
            end
        end
    end

    // clamp pulse placed by position count after the strobe ends
    always @(posedge REF_CLK_I) begin
        if (ctl_rst) begin
            armed_q <= 1'b0;
            cnt_q <= 2'h0;
            INTERNAL_CLAMP_PULSE_O <= 1'b0;
        end else begin
            INTERNAL_CLAMP_PULSE_O <= 1'b0;
            if (~VIDEO_SAMPLE_STROBE_I & strobe_q) begin
                armed_q <= 1'b1;
                cnt_q <= setup_q[`AFC_CPOS_LSB +: 2];
            end else if (armed_q) begin
                if (cnt_q == 2'h0) begin
                    armed_q <= 1'b0;
                    INTERNAL_CLAMP_PULSE_O <= clamp_dec_q;
                end else begin
                    cnt_q <= cnt_q - 2'h1;
                end
            end
        end
    end

    // static controls toward the analogue side
    always @(posedge REF_CLK_I) begin
        if (RST_I) begin
            POWER_ON_RESET_N_O <= 1'b0;
            CLAMP_POSITION_SELECT_O <= 2'h0;
            CLAMP_DAC_CODE_O <= 4'h0;
            CLAMP_DAC_ENABLE_O <= 1'b1;
            OUTPUT_NIBBLE_MODE_O <= 1'b0;
        end else begin
            POWER_ON_RESET_N_O <= por_n_q;
            CLAMP_POSITION_SELECT_O <= setup_q[`AFC_CPOS_LSB +: 2];
            CLAMP_DAC_CODE_O <= setup_q[`AFC_DAC_LSB +: 4];
            CLAMP_DAC_ENABLE_O <= ~setup_q[`AFC_EXTREF_BIT];
            OUTPUT_NIBBLE_MODE_O <= setup_q[`AFC_NIBBLE_BIT];
        end
    end

endmodule // afc_ctrl

// file: dv/afc_ctrl_asserts.sv
// port checker of afc_ctrl: bus wait states, power-on reset, routing, clamp pulse
// assumes it is bound into afc_ctrl and sees only that module's ports
`timescale 1ns/1ns
`include "afc_map.vh"

module afc_ctrl_asserts (
    input logic REF_CLK_I,
    input logic RST_I,
    input logic ANALOGUE_SUPPLY_OK_I,
    input logic DIGITAL_CORE_SUPPLY_OK_I,
    input logic VIDEO_SAMPLE_STROBE_I,
    input logic HSEL_I,
    input logic [1:0] HTRANS_I,
    input logic HWRITE_I,
    input logic HREADY_I,
    input logic HREADYOUT_O,
    input logic HRESP_O,
    input logic POWER_ON_RESET_N_O,
    input logic [2:0] SAMPLE_ENABLE_O,
    input logic [1:0] RED_CHANNEL_SOURCE_O,
    input logic [2:0] CHANNEL_POWER_O,
    input logic INTERNAL_CLAMP_PULSE_O
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);

    // a transfer taken by the slave
    wire req = HSEL_I && HREADY_I && HTRANS_I == `AFC_HTRANS_NONSEQ;
    sequence rd_req;
        req && !HWRITE_I;
    endsequence
    sequence rd_wait;
        !HREADYOUT_O [*2] ##1 HREADYOUT_O;
    endsequence

    read_wait_a: assert property (rd_req |=> rd_wait) else $error("read wait states wrong");
    write_nowait_a: assert property (req && HWRITE_I |=> HREADYOUT_O) else $error("write stalled");
    bus_okay_a: assert property (!HRESP_O) else $error("response not okay");
    supply_por_a: assert property (!ANALOGUE_SUPPLY_OK_I || !DIGITAL_CORE_SUPPLY_OK_I
        |-> ##[1:2] !POWER_ON_RESET_N_O) else $error("reset not held");
    pixel_all_a: assert property (SAMPLE_ENABLE_O == 3'b111
        |-> CHANNEL_POWER_O == 3'b111 && RED_CHANNEL_SOURCE_O == 2'h0) else $error("pixel routing");
    line_route_a: assert property (CHANNEL_POWER_O == 3'b001
        |-> SAMPLE_ENABLE_O == 3'b001 << RED_CHANNEL_SOURCE_O) else $error("line routing");
    clamp_single_a: assert property ($rose(INTERNAL_CLAMP_PULSE_O) |=> !INTERNAL_CLAMP_PULSE_O)
        else $error("clamp pulse too long");
    clamp_after_strobe_a: assert property (INTERNAL_CLAMP_PULSE_O |-> !$past(VIDEO_SAMPLE_STROBE_I, 2))
        else $error("clamp inside strobe");
endmodule // afc_ctrl_asserts

bind afc_ctrl afc_ctrl_asserts u_chk (.REF_CLK_I, .RST_I, .ANALOGUE_SUPPLY_OK_I, .DIGITAL_CORE_SUPPLY_OK_I,
    .VIDEO_SAMPLE_STROBE_I, .HSEL_I, .HTRANS_I, .HWRITE_I, .HREADY_I, .HREADYOUT_O, .HRESP_O,
    .POWER_ON_RESET_N_O, .SAMPLE_ENABLE_O, .RED_CHANNEL_SOURCE_O, .CHANNEL_POWER_O, .INTERNAL_CLAMP_PULSE_O);

// file: dv/afc_scan_model.sv
// scanner timing controller model: video sample strobe and clamp or cycle pin
// assumes its tasks are entered just after a rising clock edge
`timescale 1ns/1ns

module afc_scan_model (
    input logic clk_i,
    output logic strobe_o,
    output logic pin_o
);
    // idle with strobe and pin low
    initial begin
        strobe_o = 1'b0;
        pin_o = 1'b0;
    end

    // one pixel, strobe high for hi cycles; pin flipped after it to show only the strobe sample counts
    task automatic pixel(input logic lvl, input int hi);
        pin_o <= lvl;
        strobe_o <= 1'b1;
        repeat (hi) @(posedge clk_i);
        strobe_o <= 1'b0;
        pin_o <= ~lvl;
    endtask

    // one cycle pulse, seen low then high
    task automatic cycle();
        pin_o <= 1'b0;
        @(posedge clk_i);
        pin_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        pin_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule // afc_scan_model

// file: dv/test_afe_sampling_clamp_control.sv
// self-checking bench of afc_ctrl: register access, modes, cycling, clamp gating
// assumes afc_scan_model drives strobe and pin, and the checker is bound in
`timescale 1ns/1ns
`include "afc_map.vh"
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, e, s); end end

module test_afe_sampling_clamp_control;
    logic clk = 0, rst = 1, a_ok = 1, d_ok = 1, hsel = 0, hwr = 0;
    logic [7:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic [31:0] hwdata = 0, hrdata, rv, seed = 32'h7659_b089;
    logic hready, hresp, por_n, pulse, dac_en, nib, strobe, pin;
    logic [2:0] smp, pwr;
    logic [1:0] src, cpos;
    logic [3:0] dac;
    logic [23:0] ofs;
    logic [26:0] gn;
    logic [13:0] su;
    logic [31:0] mdl [int];
    int n_errors = 0, checked = 0, cyc = 0, at;

    // ****************
    // clock, hang guard, instances
    // ****************
    always #5 clk = ~clk;

    // cycle ceiling against a hang
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            complete_run();
        end
    end

    afc_scan_model u_scan (.clk_i(clk), .strobe_o(strobe), .pin_o(pin));
    afc_ctrl u_dut (.REF_CLK_I(clk), .RST_I(rst), .ANALOGUE_SUPPLY_OK_I(a_ok), .DIGITAL_CORE_SUPPLY_OK_I(d_ok),
        .VIDEO_SAMPLE_STROBE_I(strobe), .CLAMP_OR_CYCLE_PIN_I(pin), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwr), .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata), .POWER_ON_RESET_N_O(por_n),
        .SAMPLE_ENABLE_O(smp), .RED_CHANNEL_SOURCE_O(src), .CHANNEL_POWER_O(pwr), .CHANNEL_OFFSET_O(ofs),
        .CHANNEL_GAIN_O(gn), .INTERNAL_CLAMP_PULSE_O(pulse), .CLAMP_POSITION_SELECT_O(cpos),
        .CLAMP_DAC_CODE_O(dac), .CLAMP_DAC_ENABLE_O(dac_en), .OUTPUT_NIBBLE_MODE_O(nib));

    // ****************
    // tasks
    // ****************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // one single word transfer; read data lands in rv
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwr <= w;
        hsize <= 3'h2;
        htrans <= `AFC_HTRANS_NONSEQ;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rv = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
        mdl[a] = d & (a >= 8'h20 ? 32'h1ff : a >= 8'h10 ? 32'hff : 32'h3fff);
    endtask

    task automatic rd(input logic [7:0] a);
        bus(a, 1'b0, 32'h0);
        `CHK("rdata", mdl.exists(a) ? mdl[a] : 32'h0, rv)
        `CHK("hresp", 1'b0, hresp)
    endtask

    task automatic defaults();
        mdl.delete();
        for (int i = 0; i < 3; i++)
            mdl[`AFC_OFFSET_BASE + 4 * i] = 32'h80;
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ****************
    // scenarios
    // ****************
    initial begin
        repeat (2) @(posedge clk);
        `CHK("por", 1'b0, por_n)
        `CHK("power", 3'h7, pwr)
        `CHK("offsets", 24'h80_8080, ofs)
        `CHK("dac en", 1'b1, dac_en)
        rst <= 1'b0;
        at = 0;
        while (por_n !== 1'b1 && at++ < 20) @(posedge clk);
        `CHK("por", 1'b1, por_n)
        wr(`AFC_SWRESET_OFS, 32'h0);
        defaults();
        repeat (2) @(posedge clk);
        // each supply lost in turn: reset held, write dropped
        for (int s = 0; s < 2; s++) begin
            a_ok <= s[0];
            d_ok <= !s[0];
            repeat (3) @(posedge clk);
            `CHK("por", 1'b0, por_n)
            wr(`AFC_SETUP_OFS, 32'h3fff);
            a_ok <= 1'b1;
            d_ok <= 1'b1;
            repeat (4) @(posedge clk);
            defaults();
            rd(`AFC_SETUP_OFS);
        end
        // coefficients, unmapped place
        for (int i = 0; i < 3; i++) begin
            wr(`AFC_OFFSET_BASE + 4 * i, rnd() & 32'hff);
            wr(`AFC_GAIN_BASE + 4 * i, rnd() & 32'h1ff);
        end
        for (int i = 0; i < 3; i++) begin
            rd(`AFC_OFFSET_BASE + 4 * i);
            rd(`AFC_GAIN_BASE + 4 * i);
            `CHK("ofs out", mdl[`AFC_OFFSET_BASE + 4 * i][7:0], ofs[8 * i +: 8])
            `CHK("gain out", mdl[`AFC_GAIN_BASE + 4 * i][8:0], gn[9 * i +: 9])
        end
        bus(8'h44, 1'b1, rnd());
        rd(8'h44);
        // every mode with every input
        for (int m = 0; m < 3; m++)
            for (int s = 0; s < 3; s++) begin
                wr(`AFC_SETUP_OFS, (m << `AFC_MODE_LSB) | (s << `AFC_SEL_LSB));
                rd(`AFC_SETUP_OFS);
                `CHK("enable", m == 0 ? 3'h7 : 3'h1 << s, smp)
                `CHK("power", m == 2 ? 3'h1 : 3'h7, pwr)
                if (m == 2) begin
                    `CHK("source", s[1:0], src)
                    `CHK("gain ch0", mdl[`AFC_GAIN_BASE + 4 * s][8:0], gn[8:0])
                end
                bus(`AFC_STATUS_OFS, 1'b0, 32'h0);
                `CHK("status", {m == 2 ? 3'h1 : 3'h7, s[1:0]}, rv[4:0])
            end
        // auto cycling in line mode
        wr(`AFC_SETUP_OFS, 32'h12);
        for (int k = 1; k <= 3; k++) begin
            u_scan.cycle();
            @(posedge clk);
            `CHK("source", 2'(k % 3), src)
            `CHK("gain ch0", mdl[`AFC_GAIN_BASE + 4 * (k % 3)][8:0], gn[8:0])
            `CHK("ofs ch0", mdl[`AFC_OFFSET_BASE + 4 * (k % 3)][7:0], ofs[7:0])
        end
        // clamp gating by pin or internal bit, every position
        for (int c = 0; c < 16; c++) begin
            rv = rnd();
            su = {rv[1:0], rv[5:2], c[1:0], c[2] ~^ c[3], c[3], 4'h0};
            wr(`AFC_SETUP_OFS, 32'(su));
            u_scan.pixel(c[2] ^ c[3], 1 + c % 3);
            at = 0;
            for (int i = 1; i <= 8; i++) begin
                @(posedge clk);
                if (pulse !== 1'b0 && at == 0) at = i;
            end
            `CHK("clamp at", c[2] ? 3 + c % 4 : 0, at)
            bus(`AFC_STATUS_OFS, 1'b0, 32'h0);
            `CHK("decision", c[2], rv[5])
            `CHK("cpos", su[7:6], cpos)
            `CHK("dac", su[11:8], dac)
            `CHK("dac en", !su[12], dac_en)
            `CHK("nibble", su[13], nib)
        end
        complete_run();
    end
endmodule // test_afe_sampling_clamp_control
